// ### rtl/default_map.sv
// fixed memory map applied while protection is off
`timescale 1ns/1ps
`include "region_protection_cfg.svh"
module default_map (
  input  wire logic [31:0]                  addr,
  input  wire logic                         fetch,
  input  wire logic                         dcache_en,
  input  wire logic                         icache_en,
  input  wire logic                         unified,
  input  wire logic                         legacy,
  output region_protection_pkg::mem_attr_type attr
);
  logic icache_on;

  always_comb begin
    attr      = '{kind: region_protection_pkg::mem_normal,
                  inner: region_protection_pkg::pol_noncache,
                  outer: region_protection_pkg::pol_noncache,
                  shared: 1'b0, bufferable: 1'b0};
    icache_on = unified ? dcache_en : icache_en;
    if (legacy) begin
      attr.kind = region_protection_pkg::mem_normal;
    end else if (fetch) begin
      if (addr < `MAP_NSDEV_BASE && icache_on) begin
        attr.inner = region_protection_pkg::pol_wt;
      end
      // upper half stays normal non-cacheable
      attr.shared = 1'b0;
    end else if (addr >= `MAP_SO_BASE) begin
      attr.kind   = region_protection_pkg::mem_strongly_ordered;
      attr.shared = 1'b1;
    end else if (addr >= `MAP_SDEV_BASE) begin
      attr.kind   = region_protection_pkg::mem_shared_device;
      attr.shared = 1'b1;
      attr.bufferable = 1'b1;
    end else if (addr >= `MAP_NSDEV_BASE) begin
      attr.kind   = region_protection_pkg::mem_nonshared_device;
      attr.bufferable = 1'b1;
    end else if (!dcache_en || addr >= `MAP_NCS_BASE) begin
      attr.shared = 1'b1;
    end else if (addr >= `MAP_WT_BASE) begin
      attr.inner = region_protection_pkg::pol_wt;
      attr.bufferable = 1'b1;
    end else begin
      attr.inner = region_protection_pkg::pol_wb_wa;
      attr.bufferable = 1'b1;
    end
    attr.outer = attr.inner;
  end
endmodule : default_map

// ### rtl/region_match.sv
// one region's address match and permission decode
`timescale 1ns/1ps
`include "region_protection_cfg.svh"
module region_match (
  input  wire region_protection_pkg::region_type region,
  input  wire logic [31:0]                      addr,
  input  wire logic                             write,
  input  wire logic                             fetch,
  input  wire logic                             priv,
  input  wire logic                             legacy,
  output logic                                  hit,
  output logic                                  allowed,
  output logic                                  perm_reserved,
  output logic                                  noexec_block
);
  logic [2:0]  perm;
  logic [32:0] offset;
  logic        rd_ok;
  logic        wr_ok;

  always_comb begin
    perm   = region.attr[`ATTR_PERM_LSB +: 3];
    // full-space size of 0 means 4GB, so a background region covers everything
    offset = {1'b0, addr} - {1'b0, region.base};
    hit    = region.attr[`ATTR_EN_BIT] && (offset[32] == 1'b0)
             && ((region.size == 32'h00000000) || (offset[31:0] < region.size));
    rd_ok  = 1'b0;
    wr_ok  = 1'b0;
    perm_reserved = 1'b0;
    if (legacy) begin
      case (perm[1:0])
        2'h1: begin rd_ok = priv; wr_ok = priv; end
        2'h2: begin rd_ok = 1'b1; wr_ok = priv; end
        2'h3: begin rd_ok = 1'b1; wr_ok = 1'b1; end
        default: begin rd_ok = 1'b0; wr_ok = 1'b0; end
      endcase
    end else begin
      case (perm)
        3'h1: begin rd_ok = priv; wr_ok = priv; end
        3'h2: begin rd_ok = 1'b1; wr_ok = priv; end
        3'h3: begin rd_ok = 1'b1; wr_ok = 1'b1; end
        3'h5: begin rd_ok = priv; wr_ok = 1'b0; end
        3'h6: begin rd_ok = 1'b1; wr_ok = 1'b0; end
        3'h4, 3'h7: perm_reserved = 1'b1;
        default: begin rd_ok = 1'b0; wr_ok = 1'b0; end
      endcase
    end
    noexec_block = fetch && region.attr[`ATTR_NOEXEC_BIT];
    allowed  = (write ? wr_ok : rd_ok) && !noexec_block && !perm_reserved;
  end
endmodule : region_match

// ### rtl/region_protection_cfg.svh
// constants for the region protection unit: offsets, fields, resets, map bounds
`ifndef REGION_PROTECTION_CFG_SVH
`define REGION_PROTECTION_CFG_SVH

// wishbone register word offsets (byte addresses)
`define OFF_CONTROL      8'h00
`define OFF_REGION_SEL   8'h04
`define OFF_REGION_BASE  8'h08
`define OFF_REGION_SIZE  8'h0C
`define OFF_REGION_ATTR  8'h10
`define OFF_FAULT_STATUS 8'h14
`define OFF_FAULT_ADDR   8'h18

// control register fields
`define CTL_PROT_EN_BIT  0
`define CTL_DCACHE_BIT   2
`define CTL_PREDICT_BIT  11
`define CTL_ICACHE_BIT   12
`define CTL_LEGACY_BIT   16
`define CTL_UNIFIED_BIT  17
`define CTL_RESET        32'h00000000

// region attribute word fields
`define ATTR_EN_BIT      0
`define ATTR_PERM_LSB    1
`define ATTR_NOEXEC_BIT  4
`define ATTR_B_BIT       5
`define ATTR_C_BIT       6
`define ATTR_TEX_LSB     7
`define ATTR_S_BIT       10

// default map boundaries
`define MAP_WT_BASE      32'h40000000
`define MAP_NCS_BASE     32'h60000000
`define MAP_NSDEV_BASE   32'h80000000
`define MAP_SDEV_BASE    32'hA0000000
`define MAP_SO_BASE      32'hC0000000

// fault status codes
`define FS_NONE          4'h0
`define FS_BACKGROUND    4'h1
`define FS_PERMISSION    4'hD
`define FS_EXEC_NEVER    4'hE
`define FS_RESERVED_PERM 4'hF

`endif

// ### rtl/region_protection_check.sv
// region protection unit: access check, default map and wishbone registers
`timescale 1ns/1ps
`include "region_protection_cfg.svh"
// Operation
// - an address matching no enabled region aborts and does not proceed
// - a hit region's permission field is checked against access type and privilege
// - a permitted access takes its attributes from the winning region
// - among overlapping hits the highest-numbered region wins
// - region 0 spanning 4GB acts as background instead of abort
// - the forwarded address always equals the processor address
// - region configuration is read and written only from privileged mode
// - control bit 0 enables protection; reset clears it
// - older variant with protection off: non-cacheable, unbufferable, no aborts
// - newer variant with protection off: no checks, no aborts, default map types
// - protection off: data below 2GB cacheable only when bit 2 set
// - data map: write-back allocate, write-through, non-cacheable shared by range
// - data map upper ranges: strongly ordered, shared device, non-shared device
// - separate caches: fetch below 2GB write-through when bit 12 set
// - protection off: fetch in upper 2GB is normal non-cacheable
// - unified cache: fetch below 2GB cacheable only with bit 2
// - branch prediction follows bit 11 regardless of protection
// - prefetch operations do nothing when the matching cache is off; a fetch prefetch follows bit 12 even with a unified cache
// - tightly coupled memory hits are normal, non-shared, non-cacheable
// - protection off: outer attributes equal inner attributes
// - newer variant records abort cause and address in fault registers
// - three-bit permission decode with 100 and 111 reserved
// - fetch needs read permission and execute-never bit clear
module region_protection_check #(
  parameter int REGIONS = 8
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [7:0]                            wb_adr_i,
  input  wire logic [3:0]                            wb_sel_i,
  input  wire logic [31:0]                           wb_dat_i,
  input  wire logic                                  wb_priv_i,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  output logic                                       wb_err_o,
  input  wire region_protection_pkg::access_req_type req,
  input  wire logic                                  tcm_hit,
  input  wire logic                                  prefetch_op,
  output region_protection_pkg::access_rsp_type      rsp,
  output logic                                       predict_en,
  output logic                                       prefetch_go
);
  localparam int SEL_W = $clog2(REGIONS);

  typedef struct packed {
    logic [31:0]                          control;
    logic [SEL_W-1:0]                     sel;
    region_protection_pkg::region_type [REGIONS-1:0] regions;
    logic [3:0]                           fault_status;
    logic [31:0]                          fault_addr;
    logic [31:0]                          rdata;
    logic                                 ack;
    logic                                 err;
    region_protection_pkg::access_rsp_type rsp;
    logic                                 predict;
    logic                                 prefetch;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [REGIONS-1:0] hit;
  logic [REGIONS-1:0] allowed;
  logic [REGIONS-1:0] perm_res;
  logic [REGIONS-1:0] noexec_blk;
  region_protection_pkg::mem_attr_type dflt_attr;

  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : g_region
      region_match u_match (
        .region        (s_q.regions[g]),
        .addr          (req.addr),
        .write         (req.write),
        .fetch         (req.fetch),
        .priv          (req.priv),
        .legacy        (s_q.control[`CTL_LEGACY_BIT]),
        .hit           (hit[g]),
        .allowed       (allowed[g]),
        .perm_reserved (perm_res[g]),
        .noexec_block  (noexec_blk[g])
      );
    end
  endgenerate

  default_map u_default (
    .addr      (req.addr),
    .fetch     (req.fetch),
    .dcache_en (s_q.control[`CTL_DCACHE_BIT]),
    .icache_en (s_q.control[`CTL_ICACHE_BIT]),
    .unified   (s_q.control[`CTL_UNIFIED_BIT]),
    .legacy    (s_q.control[`CTL_LEGACY_BIT]),
    .attr      (dflt_attr)
  );

  // translate a region's C/B/TEX/S bits into a memory type
  function automatic region_protection_pkg::mem_attr_type region_attr(
    input logic [10:0] a,
    input logic        legacy
  );
    region_protection_pkg::mem_attr_type r;
    logic [2:0] tex;
    logic [1:0] cb;
    tex = a[`ATTR_TEX_LSB +: 3];
    cb  = {a[`ATTR_C_BIT], a[`ATTR_B_BIT]};
    r   = '{kind: region_protection_pkg::mem_normal,
            inner: region_protection_pkg::pol_noncache,
            outer: region_protection_pkg::pol_noncache,
            shared: a[`ATTR_S_BIT], bufferable: a[`ATTR_B_BIT]};
    if (legacy) begin
      r.inner = a[`ATTR_C_BIT] ? region_protection_pkg::pol_wb_nwa
                               : region_protection_pkg::pol_noncache;
      r.shared = 1'b0;
    end else if (tex[2]) begin
      r.inner = region_protection_pkg::cache_pol_type'(cb);
      r.outer = region_protection_pkg::cache_pol_type'(tex[1:0]);
    end else begin
      case ({tex[1:0], cb})
        4'h0: begin r.kind = region_protection_pkg::mem_strongly_ordered; r.shared = 1'b1; end
        4'h1: begin r.kind = region_protection_pkg::mem_shared_device; r.shared = 1'b1; end
        4'h2: r.inner = region_protection_pkg::pol_wt;
        4'h3: r.inner = region_protection_pkg::pol_wb_nwa;
        4'h7: r.inner = region_protection_pkg::pol_wb_wa;
        4'h8: begin r.kind = region_protection_pkg::mem_nonshared_device; r.shared = 1'b0; end
        default: r.inner = region_protection_pkg::pol_noncache;
      endcase
      if (r.kind == region_protection_pkg::mem_normal) begin
        r.outer = r.inner;
      end
    end
    return r;
  endfunction : region_attr

  always_comb begin
    int          win;
    logic        any_hit;
    logic        enabled;
    logic        legacy;
    logic        abort;
    logic [3:0]  cause;
    logic [31:0] wmask;
    logic        bus_req;
    win     = 0;
    any_hit = 1'b0;
    abort   = 1'b0;
    cause   = `FS_NONE;
    wmask   = 32'h00000000;
    bus_req = 1'b0;
    s_d     = s_q;
    enabled = s_q.control[`CTL_PROT_EN_BIT];
    legacy  = s_q.control[`CTL_LEGACY_BIT];
    for (int i = 0; i < REGIONS; i++) begin
      if (hit[i]) begin
        win     = i;
        any_hit = 1'b1;
      end
    end
    if (enabled && !tcm_hit) begin
      if (!any_hit) begin
        abort = 1'b1;
        cause = `FS_BACKGROUND;
      end else if (!allowed[win]) begin
        abort = 1'b1;
        cause = perm_res[win] ? `FS_RESERVED_PERM
              : noexec_blk[win] ? `FS_EXEC_NEVER : `FS_PERMISSION;
      end
    end
    // the response is registered so abort and attributes leave together
    s_d.rsp.valid     = req.valid;
    s_d.rsp.phys_addr = req.addr;
    s_d.rsp.write     = req.write;
    s_d.rsp.fetch     = req.fetch;
    s_d.rsp.abort     = req.valid && abort;
    if (tcm_hit) begin
      s_d.rsp.attr = '{kind: region_protection_pkg::mem_normal,
                       inner: region_protection_pkg::pol_noncache,
                       outer: region_protection_pkg::pol_noncache,
                       shared: 1'b0, bufferable: 1'b0};
    end else if (!enabled) begin
      s_d.rsp.attr = dflt_attr;
    end else begin
      s_d.rsp.attr = region_attr(s_q.regions[win].attr, legacy);
    end
    if (req.valid && abort && !legacy) begin
      s_d.fault_status = cause;
      s_d.fault_addr   = req.addr;
    end
    s_d.predict  = s_q.control[`CTL_PREDICT_BIT];
    s_d.prefetch = prefetch_op && (req.fetch ? s_q.control[`CTL_ICACHE_BIT]
                                             : s_q.control[`CTL_DCACHE_BIT]);

    // wishbone slave, one wait state, ack dropped the cycle after
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    bus_req = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    s_d.rdata = 32'h00000000;
    if (bus_req) begin
      if (!wb_priv_i) begin
        s_d.err = 1'b1;
      end else if (wb_adr_i == `OFF_CONTROL) begin
        s_d.ack = 1'b1;
        s_d.rdata = s_q.control;
        if (wb_we_i) begin
          s_d.control = (s_q.control & ~wmask) | (wb_dat_i & wmask);
        end
      end else if (wb_adr_i == `OFF_REGION_SEL) begin
        s_d.ack = 1'b1;
        s_d.rdata = 32'(s_q.sel);
        if (wb_we_i && wb_sel_i[0]) begin
          s_d.sel = wb_dat_i[SEL_W-1:0];
        end
      end else if (wb_adr_i == `OFF_REGION_BASE) begin
        s_d.ack = 1'b1;
        s_d.rdata = s_q.regions[s_q.sel].base;
        if (wb_we_i) begin
          s_d.regions[s_q.sel].base = (s_q.regions[s_q.sel].base & ~wmask) | (wb_dat_i & wmask);
        end
      end else if (wb_adr_i == `OFF_REGION_SIZE) begin
        s_d.ack = 1'b1;
        s_d.rdata = s_q.regions[s_q.sel].size;
        if (wb_we_i) begin
          s_d.regions[s_q.sel].size = (s_q.regions[s_q.sel].size & ~wmask) | (wb_dat_i & wmask);
        end
      end else if (wb_adr_i == `OFF_REGION_ATTR) begin
        s_d.ack = 1'b1;
        s_d.rdata = {21'h00000, s_q.regions[s_q.sel].attr};
        if (wb_we_i) begin
          s_d.regions[s_q.sel].attr = (s_q.regions[s_q.sel].attr & ~wmask[10:0])
                                    | (wb_dat_i[10:0] & wmask[10:0]);
        end
      end else if (wb_adr_i == `OFF_FAULT_STATUS) begin
        s_d.ack = 1'b1;
        s_d.rdata = {28'h0000000, s_q.fault_status};
        if (wb_we_i && !(req.valid && abort && !legacy)) begin
          s_d.fault_status = `FS_NONE;
        end
      end else if (wb_adr_i == `OFF_FAULT_ADDR) begin
        s_d.ack = 1'b1;
        s_d.rdata = s_q.fault_addr;
      end else begin
        s_d.err = 1'b1;
      end
    end
    if (rst) begin
      s_d = '0;
      s_d.control = `CTL_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  always_comb begin
    wb_dat_o    = s_q.rdata;
    wb_ack_o    = s_q.ack;
    wb_err_o    = s_q.err;
    rsp         = s_q.rsp;
    predict_en  = s_q.predict;
    prefetch_go = s_q.prefetch;
  end
endmodule : region_protection_check

// ### rtl/region_protection_pkg.sv
// types shared by the region protection unit files
package region_protection_pkg;

  typedef enum logic [2:0] {
    mem_strongly_ordered,
    mem_shared_device,
    mem_nonshared_device,
    mem_normal
  } mem_kind_type;

  typedef enum logic [1:0] {
    pol_noncache,
    pol_wb_wa,
    pol_wt,
    pol_wb_nwa
  } cache_pol_type;

  typedef struct packed {
    mem_kind_type  kind;
    cache_pol_type inner;
    cache_pol_type outer;
    logic          shared;
    logic          bufferable;
  } mem_attr_type;

  typedef struct packed {
    logic       valid;
    logic [31:0] addr;
    logic       write;
    logic       fetch;
    logic       priv;
  } access_req_type;

  typedef struct packed {
    logic         valid;
    logic [31:0]  phys_addr;
    logic         write;
    logic         fetch;
    logic         abort;
    mem_attr_type attr;
  } access_rsp_type;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] size;
    logic [10:0] attr;
  } region_type;

  typedef enum logic [1:0] {
    bus_idle,
    bus_ack
  } bus_state_type;

endpackage : region_protection_pkg

// ### tb/core_access_model.sv
// processor-side model: one access at a time, answer collected after the taking edge
`timescale 1ns/1ps
module core_access_model (
  input  wire logic                                  clk,
  input  wire region_protection_pkg::access_rsp_type rsp,
  input  wire logic                                  prefetch_go,
  output region_protection_pkg::access_req_type      req,
  output logic                                       tcm_hit,
  output logic                                       prefetch_op
);
  initial begin
    req = '0;
    tcm_hit = 1'b0;
    prefetch_op = 1'b0;
  end

  // k = {prefetch, tcm, privileged, fetch, write}
  task automatic access(input logic [31:0] a, input logic [4:0] k,
                        output region_protection_pkg::access_rsp_type r, output logic go);
    @(posedge clk);
    req <= '{1'b1, a, k[0], k[1], k[2]};
    tcm_hit <= k[3];
    prefetch_op <= k[4];
    @(posedge clk);
    // released lines inverted so a stale value never passes for a live one
    req <= '{1'b0, ~a, ~k[0], ~k[1], ~k[2]};
    tcm_hit <= 1'b0;
    prefetch_op <= 1'b0;
    @(posedge clk);
    r = rsp;
    go = prefetch_go;
  endtask : access
endmodule : core_access_model

// ### tb/region_protection_check_props.sv
// port-level assertions for the region protection unit
`timescale 1ns/1ps
module region_protection_check_props #(
  parameter int REGIONS = 8
) (
  input wire logic                                  clk,
  input wire logic                                  rst,
  input wire logic                                  wb_cyc_i,
  input wire logic                                  wb_stb_i,
  input wire logic                                  wb_priv_i,
  input wire logic [31:0]                           wb_dat_o,
  input wire logic                                  wb_ack_o,
  input wire logic                                  wb_err_o,
  input wire region_protection_pkg::access_req_type req,
  input wire logic                                  tcm_hit,
  input wire logic                                  prefetch_op,
  input wire region_protection_pkg::access_rsp_type rsp,
  input wire logic                                  prefetch_go
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  phys_addr_a: assert property (rsp.valid |-> rsp.phys_addr == $past(req.addr))
    else $error("forwarded address differs from request");
  valid_follow_a: assert property (!$past(rst) |-> rsp.valid == $past(req.valid))
    else $error("answer not one cycle after request");
  dir_pass_a: assert property (rsp.valid |-> rsp.write == $past(req.write)
    && rsp.fetch == $past(req.fetch))
    else $error("access direction lost");
  abort_valid_a: assert property (rsp.abort |-> rsp.valid)
    else $error("abort without access");
  tcm_attr_a: assert property (rsp.valid && $past(tcm_hit) |-> !rsp.abort && !rsp.attr.shared
    && rsp.attr.kind == region_protection_pkg::mem_normal
    && rsp.attr.inner == region_protection_pkg::pol_noncache)
    else $error("coupled memory attributes wrong");
  user_refused_a: assert property (wb_cyc_i && wb_stb_i && !wb_priv_i && !wb_ack_o && !wb_err_o
    |=> wb_err_o && !wb_ack_o)
    else $error("user register access not refused");
  err_data_a: assert property (wb_err_o |-> wb_dat_o == 32'h00000000)
    else $error("refused access returns data");
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o ^ wb_err_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  pf_cause_a: assert property (prefetch_go |-> $past(prefetch_op))
    else $error("prefetch without prefetch request");

  cover property (rsp.valid && rsp.abort);
  cover property (wb_err_o);
  cover property (prefetch_go);
  cover property (rsp.valid && $past(tcm_hit));
endmodule : region_protection_check_props

bind region_protection_check region_protection_check_props #(.REGIONS(REGIONS)) props_i (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_priv_i(wb_priv_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .req(req),
  .tcm_hit(tcm_hit), .prefetch_op(prefetch_op), .rsp(rsp), .prefetch_go(prefetch_go)
);

// ### tb/region_protection_check_tb.sv
// self-checking bench for the region protection unit
`timescale 1ns/1ps
`include "region_protection_cfg.svh"
module region_protection_check_tb;
  localparam logic [2:0] so = region_protection_pkg::mem_strongly_ordered;
  localparam logic [2:0] sd = region_protection_pkg::mem_shared_device;
  localparam logic [2:0] nd = region_protection_pkg::mem_nonshared_device;
  localparam logic [2:0] nm = region_protection_pkg::mem_normal;
  localparam logic [1:0] nc = region_protection_pkg::pol_noncache;
  localparam logic [1:0] wa = region_protection_pkg::pol_wb_wa;
  localparam logic [1:0] wt = region_protection_pkg::pol_wt;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, priv, ack, err, predict, go_w, tightly_coupled_memory, pfo, go, e;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [4:0]  x;
  int          num_errors = 0;
  int          checks = 0;
  region_protection_pkg::access_req_type req;
  region_protection_pkg::access_rsp_type rsp, r;
  logic [31:0] maps [8] = '{32'h100, 32'h3FFFFFFC, 32'h40000000, 32'h60000000,
                            32'h7FFFFFFC, 32'h80000000, 32'hA0000000, 32'hC0000000};
  logic [31:0] ta [8] = '{32'h3010, 32'h3010, 32'h10, 32'h8000,
                          32'h9000, 32'h21000, 32'h20FFF, 32'h8000};
  logic [4:0]  tk [8] = '{5'h00, 5'h01, 5'h00, 5'h06, 5'h04, 5'h04, 5'h00, 5'h04};
  logic [3:0]  tf [8] = '{4'h0, 4'hD, 4'hD, 4'hE, 4'hF, 4'h1, 4'h0, 4'h0};

  always #50 clk = ~clk;

  region_protection_check #(.REGIONS(8)) dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_priv_i(priv), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .req(req), .tcm_hit(tightly_coupled_memory), .prefetch_op(pfo), .rsp(rsp),
    .predict_en(predict), .prefetch_go(go_w)
  );
  core_access_model core (
    .clk(clk), .rsp(rsp), .prefetch_go(go_w), .req(req), .tcm_hit(tightly_coupled_memory), .prefetch_op(pfo)
  );

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // one classic cycle; ack/err read at the edge that samples it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic p);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, priv} <= {2'b11, w, a, d, p};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
    rd = rdat;
    e = err;
    {cyc, stb, we, adr, wdat} <= {3'b000, ~a, ~d};
  endtask : wb

  task automatic set_region(input logic [31:0] i, b, s, a);
    wb(1, `OFF_REGION_SEL, i, 1);
    wb(1, `OFF_REGION_BASE, b, 1);
    wb(1, `OFF_REGION_SIZE, s, 1);
    wb(1, `OFF_REGION_ATTR, a, 1);
  endtask : set_region

  // expected {kind, inner policy} with protection off
  function automatic logic [4:0] dmap(input logic [31:0] a, input logic f, dc, ic);
    if (f) return {nm, (a[31] || !ic) ? nc : wt};
    if (a >= `MAP_SO_BASE) return {so, nc};
    if (a >= `MAP_SDEV_BASE) return {sd, nc};
    if (a >= `MAP_NSDEV_BASE) return {nd, nc};
    if (!dc || a >= `MAP_NCS_BASE) return {nm, nc};
    return {nm, (a >= `MAP_WT_BASE) ? wt : wa};
  endfunction : dmap

  function automatic logic allow(input logic [2:0] p, input logic pv, w);
    case (p)
      3'h1: return pv;
      3'h2: return pv || !w;
      3'h3: return 1'b1;
      3'h5: return pv && !w;
      3'h6: return !w;
      default: return 1'b0;
    endcase
  endfunction : allow

  initial begin
    {cyc, stb, we, priv, adr, wdat} = '0;
    sel = 4'hF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(0, `OFF_CONTROL, 0, 1);
    check("control reset", rd, 0);
    check("predict reset", predict, 0);
    wb(0, 8'h1C, 0, 1);
    check("unmapped err", e, 1);
    wb(1, `OFF_CONTROL, 32'h1, 0);
    check("user write err", e, 1);
    wb(0, `OFF_CONTROL, 0, 1);
    check("user write ignored", rd, 0);
    set_region(6, 0, 0, 32'hFFFFF800);
    wb(0, `OFF_REGION_ATTR, 0, 1);
    check("attr upper bits", rd, 0);
    for (int m = 0; m < 4; m++) begin
      wb(1, `OFF_CONTROL, {19'h0, m[1], 1'b1, 8'h0, m[0], 2'h0}, 1);
      // prediction output follows the control write one edge later
      @(posedge clk);
      check("predict", predict, 1);
      for (int i = 0; i < 16; i++) begin
        core.access(maps[i[2:0]], {3'b101, i[3], 1'b0}, r, go);
        x = dmap(maps[i[2:0]], i[3], m[0], m[1]);
        check("kind", r.attr.kind, x[4:2]);
        check("inner", r.attr.inner, x[1:0]);
        check("outer", r.attr.outer, x[1:0]);
        check("no abort", r.abort, 0);
        check("prefetch", go, i[3] ? m[1] : m[0]);
      end
    end
    wb(1, `OFF_CONTROL, 32'h00020004, 1);
    core.access(32'h100, 5'h06, r, go);
    check("unified fetch", r.attr.inner != nc, 1);
    check("predict off", predict, 0);
    core.access(32'h80000000, 5'h06, r, go);
    check("unified upper", r.attr.inner, nc);
    wb(1, `OFF_CONTROL, 32'h00010004, 1);
    core.access(32'h100, 5'h05, r, go);
    check("legacy", {r.attr.kind, r.attr.inner, r.attr.bufferable, r.abort}, {nm, nc, 2'b0});
    // regions set up before the enable, caches left off
    set_region(1, 0, 32'h4000, 32'h003);
    set_region(2, 32'h3000, 32'h1000, 32'h045);
    set_region(3, 32'h8000, 32'h1000, 32'h017);
    set_region(4, 32'h9000, 32'h1000, 32'h009);
    set_region(5, 32'h20000, 32'h1000, 32'h007);
    wb(1, `OFF_CONTROL, 32'h1, 1);
    for (int i = 0; i < 8; i++) begin
      core.access(ta[i], tk[i], r, go);
      check("abort", r.abort, tf[i] != 0);
      check("phys addr", r.phys_addr, ta[i]);
      if (i == 0) check("region attr", {r.attr.kind, r.attr.inner}, {nm, wt});
      wb(0, `OFF_FAULT_STATUS, 0, 1);
      check("fault code", rd[3:0], tf[i]);
      wb(0, `OFF_FAULT_ADDR, 0, 1);
      if (tf[i] != 0) check("fault addr", rd, ta[i]);
      wb(1, `OFF_FAULT_STATUS, 0, 1);
    end
    for (int p = 0; p < 8; p++) begin
      wb(1, `OFF_REGION_SEL, 5, 1);
      wb(1, `OFF_REGION_ATTR, {p[2:0], 1'b1}, 1);
      for (int k = 0; k < 4; k++) begin
        core.access(32'h20FFF, {2'b00, k[1], 1'b0, k[0]}, r, go);
        check("perm", r.abort, !allow(p[2:0], k[1], k[0]));
      end
    end
    core.access(32'h21000, 5'h0C, r, go);
    check("tcm", {r.abort, r.attr.kind, r.attr.inner, r.attr.shared}, {1'b0, nm, nc, 1'b0});
    set_region(0, 0, 0, 32'h007);
    core.access(32'h00100000, 5'h00, r, go);
    check("background", r.abort, 0);
    wb(1, `OFF_CONTROL, 32'h00010001, 1);
    core.access(32'h10, 5'h00, r, go);
    check("legacy perm", r.abort, 1);
    summarize();
  end
endmodule : region_protection_check_tb
